// File: compare_channel.sv
module compare_channel (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Events and settings
	input wire logic match_event,
	input wire logic force_event,
	input wire logic bottom_event,
	input wire logic pwm_mode,
	input wire logic [1:0] compare_output_mode,
	// Output state
	output logic compare_output
);

	typedef struct packed {
		logic oc;
	} chan_state_type;

	chan_state_type state_reg;
	chan_state_type state_next;

	// Output action at match, force or bottom
	always_comb begin
		state_next = state_reg;
		if (!pwm_mode) begin
			if (match_event || force_event) begin
				unique case (compare_output_mode)
					timer16_pkg::COM_NONE: state_next.oc = state_reg.oc;
					timer16_pkg::COM_TOGGLE: state_next.oc = ~state_reg.oc;
					timer16_pkg::COM_CLEAR: state_next.oc = 1'b0;
					timer16_pkg::COM_SET: state_next.oc = 1'b1;
				endcase
			end
		end else begin
			// Inverted or non-inverted waveform
			if (match_event) begin
				if (compare_output_mode == timer16_pkg::COM_CLEAR) state_next.oc = 1'b0;
				if (compare_output_mode == timer16_pkg::COM_SET) state_next.oc = 1'b1;
			end else if (bottom_event) begin
				if (compare_output_mode == timer16_pkg::COM_CLEAR) state_next.oc = 1'b1;
				if (compare_output_mode == timer16_pkg::COM_SET) state_next.oc = 1'b0;
			end
		end
	end

	// State register, cleared on reset and by clear actions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) state_reg <= '{oc: timer16_pkg::OC_RESET};
		else state_reg <= state_next;
	end

	assign compare_output = state_reg.oc;

	property p_idle_hold;
		@(posedge pclk) disable iff (!presetn)
		!match_event && !force_event && !bottom_event |=> $stable(compare_output);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("output moved without event");

	property p_com_none;
		@(posedge pclk) disable iff (!presetn)
		match_event && compare_output_mode == timer16_pkg::COM_NONE |=> $stable(compare_output);
	endproperty
	a_com_none: assert property (p_com_none) else $error("mode none changed output");

endmodule // compare_channel

// File: pin_pad_model.sv
module pin_pad_model #(
	parameter logic pull_level = 1'b0
) (
	// Pins from the timer
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe,
	// Level seen on the board
	output logic [1:0] pad_level
);
	timeunit 1ns;
	timeprecision 1ps;

	// Undriven pad settles to its pull resistor, never the last value
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pad_level[i] = pin_oe[i] ? pin_out[i] : pull_level;
		end
	end
endmodule // pin_pad_model

// File: timer16_compare_output_normal.sv
// Function
// - In non-PWM modes, force strobe applies current output action as a real match would.
// - Force strobe sets no match flag and leaves counter alone.
// - Counter write blocks every match in the following timer tick.
// - Writing counter to variable TOP skips that TOP; counts on to max.
// - Output register keeps its value across waveform mode changes.
// - Output mode bits are not buffered; effective immediately.
// - New output mode governs the first match after writing.
// - Reset clears each channel output register to 0.
// - Nonzero output mode replaces port value on pin; direction from port.
// - Output value reaches pin only when direction selects output.
// - Output mode 0 leaves output register unchanged at match.
// - Output mode bits do not affect input capture.
// - Counting depends only on waveform mode, not output mode.
// - Non-PWM: set, clear, toggle; PWM: inverted or non-inverted.
// - Normal mode counts up, never clears on match, wraps to zero.
// - Normal mode overflow flag sets as counter becomes zero.
// - Overflow flag clears when its interrupt is executed.
// - Normal mode accepts counter writes at any time.
// - Comparator checks counter against each compare value continuously.
// - Match sets the channel match flag at the next timer tick.
// - Writing one clears a match flag; interrupt execution clears too.
//
// The APB interface to the registers and the address map were decided locally.
module timer16_compare_output_normal #(
	parameter int count_width = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer clock from prescaler
	input wire logic timer_tick,
	// Interrupt execution acknowledges
	input wire logic overflow_ack,
	input wire logic [1:0] compare_ack,
	// Interrupt request
	output logic irq,
	// Compare output pins
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe
);

	typedef struct packed {
		logic [count_width-1:0] counter_value;
		logic [count_width-1:0] compare_a;
		logic [count_width-1:0] compare_b;
		logic [1:0] com_a;
		logic [1:0] com_b;
		logic [3:0] wgm;
		logic run;
		logic [2:0] flags;
		logic [2:0] irq_en;
		logic [1:0] port_val;
		logic [1:0] pin_direction_bit;
		logic block;
		logic [1:0] pin_out;
		logic [1:0] pin_oe;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_type;

	state_type state_reg;
	state_type state_next;

	localparam logic [count_width-1:0] count_max = '1;
	localparam logic [count_width-1:0] count_one = {{(count_width-1){1'b0}}, 1'b1};

	// Known register offsets
	function automatic logic mapped(input logic [7:0] addr);
		unique case (addr)
			timer16_pkg::OFF_CONTROL_A, timer16_pkg::OFF_CONTROL_B,
			timer16_pkg::OFF_CONTROL_C, timer16_pkg::OFF_COUNTER,
			timer16_pkg::OFF_COMPARE_A, timer16_pkg::OFF_COMPARE_B,
			timer16_pkg::OFF_FLAGS, timer16_pkg::OFF_IRQ_ENABLE,
			timer16_pkg::OFF_PORT, timer16_pkg::OFF_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	// Mode is one with a PWM waveform
	function automatic logic is_pwm(input logic [3:0] wgm);
		is_pwm = (wgm != timer16_pkg::WGM_NORMAL) && (wgm != timer16_pkg::WGM_CTC_A)
			&& (wgm != 4'hC);
	endfunction

	logic oc_a;
	logic oc_b;
	logic access;
	logic wr;
	logic wr_cnt;
	logic tick;
	logic match_a;
	logic match_b;
	logic ev_a;
	logic ev_b;
	logic force_a;
	logic force_b;
	logic top_clear;
	logic wrap;
	logic ovf_set;
	logic bottom_ev;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;
	logic [31:0] rdata;

	// Bus strobes and timer events
	assign access = psel && penable && state_reg.pready;
	assign wr = access && pwrite;
	assign wr_cnt = wr && paddr == timer16_pkg::OFF_COUNTER;
	assign tick = timer_tick && state_reg.run;
	assign match_a = state_reg.counter_value == state_reg.compare_a;
	assign match_b = state_reg.counter_value == state_reg.compare_b;
	assign ev_a = tick && match_a && !state_reg.block && !wr_cnt;
	assign ev_b = tick && match_b && !state_reg.block && !wr_cnt;
	assign force_a = wr && paddr == timer16_pkg::OFF_CONTROL_C
		&& pwdata[timer16_pkg::FORCE_A_POS] && !is_pwm(state_reg.wgm);
	assign force_b = wr && paddr == timer16_pkg::OFF_CONTROL_C
		&& pwdata[timer16_pkg::FORCE_B_POS] && !is_pwm(state_reg.wgm);
	// TOP from compare A; a blocked TOP lets the counter run to max
	assign top_clear = ev_a && (state_reg.wgm == timer16_pkg::WGM_CTC_A
		|| state_reg.wgm == timer16_pkg::WGM_FAST_PWM_A);
	assign wrap = tick && !wr_cnt && !top_clear && state_reg.counter_value == count_max;
	assign ovf_set = wrap || (top_clear && state_reg.wgm == timer16_pkg::WGM_FAST_PWM_A);
	assign bottom_ev = tick && !wr_cnt && (top_clear || wrap);
	assign flag_set = {ev_b, ev_a, ovf_set};
	assign flag_clr = {compare_ack, overflow_ack}
		| ((wr && paddr == timer16_pkg::OFF_FLAGS) ? pwdata[2:0] : 3'h0);

	// Read mux
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (paddr)
			timer16_pkg::OFF_CONTROL_A: begin
				rdata[timer16_pkg::COM_A_POS +: 2] = state_reg.com_a;
				rdata[timer16_pkg::COM_B_POS +: 2] = state_reg.com_b;
				rdata[timer16_pkg::WGM_POS +: 4] = state_reg.wgm;
			end
			timer16_pkg::OFF_CONTROL_B: rdata[timer16_pkg::RUN_POS] = state_reg.run;
			timer16_pkg::OFF_COUNTER: rdata[count_width-1:0] = state_reg.counter_value;
			timer16_pkg::OFF_COMPARE_A: rdata[count_width-1:0] = state_reg.compare_a;
			timer16_pkg::OFF_COMPARE_B: rdata[count_width-1:0] = state_reg.compare_b;
			timer16_pkg::OFF_FLAGS: rdata[2:0] = state_reg.flags;
			timer16_pkg::OFF_IRQ_ENABLE: rdata[2:0] = state_reg.irq_en;
			timer16_pkg::OFF_PORT: begin
				rdata[timer16_pkg::PORT_VAL_POS +: 2] = state_reg.port_val;
				rdata[timer16_pkg::PORT_DIR_POS +: 2] = state_reg.pin_direction_bit;
			end
			timer16_pkg::OFF_STATUS: rdata[1:0] = {oc_b, oc_a};
			default: rdata = 32'h0000_0000;
		endcase
	end

	// Next state of the whole block
	always_comb begin
		state_next = state_reg;
		// One wait state, then the answer
		state_next.pready = psel && penable && !state_reg.pready;
		state_next.pslverr = psel && penable && !state_reg.pready && !mapped(paddr);
		if (psel && penable && !state_reg.pready) state_next.prdata = rdata;
		// Register writes
		if (wr) begin
			unique case (paddr)
				timer16_pkg::OFF_CONTROL_A: begin
					state_next.com_a = pwdata[timer16_pkg::COM_A_POS +: 2];
					state_next.com_b = pwdata[timer16_pkg::COM_B_POS +: 2];
					state_next.wgm = pwdata[timer16_pkg::WGM_POS +: 4];
				end
				timer16_pkg::OFF_CONTROL_B: state_next.run = pwdata[timer16_pkg::RUN_POS];
				timer16_pkg::OFF_COMPARE_A: state_next.compare_a = pwdata[count_width-1:0];
				timer16_pkg::OFF_COMPARE_B: state_next.compare_b = pwdata[count_width-1:0];
				timer16_pkg::OFF_IRQ_ENABLE: state_next.irq_en = pwdata[2:0];
				timer16_pkg::OFF_PORT: begin
					state_next.port_val = pwdata[timer16_pkg::PORT_VAL_POS +: 2];
					state_next.pin_direction_bit = pwdata[timer16_pkg::PORT_DIR_POS +: 2];
				end
				default: state_next.run = state_reg.run;
			endcase
		end
		// Counter: a write wins and arms the block
		if (wr_cnt) begin
			state_next.counter_value = pwdata[count_width-1:0];
			state_next.block = 1'b1;
		end else if (tick) begin
			state_next.block = 1'b0;
			if (top_clear) state_next.counter_value = '0;
			else state_next.counter_value = state_reg.counter_value + count_one;
		end
		// Flags: a set beats a clear in the same cycle
		state_next.flags = (state_reg.flags & ~flag_clr) | flag_set;
		state_next.irq = |(state_next.flags & state_next.irq_en);
		// Pin source and direction
		state_next.pin_out[0] = (state_reg.com_a != timer16_pkg::COM_NONE) ? oc_a
			: state_reg.port_val[0];
		state_next.pin_out[1] = (state_reg.com_b != timer16_pkg::COM_NONE) ? oc_b
			: state_reg.port_val[1];
		state_next.pin_oe = state_reg.pin_direction_bit;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			state_reg.com_a <= timer16_pkg::COM_RESET;
			state_reg.com_b <= timer16_pkg::COM_RESET;
			state_reg.wgm <= timer16_pkg::WGM_RESET;
			state_reg.flags <= timer16_pkg::FLAGS_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Compare channels; force never touches flags or counter
	compare_channel chan_a (
		.pclk(pclk),
		.presetn(presetn),
		.match_event(ev_a),
		.force_event(force_a),
		.bottom_event(bottom_ev),
		.pwm_mode(is_pwm(state_reg.wgm)),
		.compare_output_mode(state_reg.com_a),
		.compare_output(oc_a)
	);

	compare_channel chan_b (
		.pclk(pclk),
		.presetn(presetn),
		.match_event(ev_b),
		.force_event(force_b),
		.bottom_event(bottom_ev),
		.pwm_mode(is_pwm(state_reg.wgm)),
		.compare_output_mode(state_reg.com_b),
		.compare_output(oc_b)
	);

	// Outputs straight from flip-flops
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign irq = state_reg.irq;
	assign pin_out = state_reg.pin_out;
	assign pin_oe = state_reg.pin_oe;

	sequence s_force_alone;
		force_a && !ev_a && !compare_ack[0];
	endsequence

	property p_force_no_flag;
		@(posedge pclk) disable iff (!presetn)
		s_force_alone and !state_reg.flags[timer16_pkg::CMP_A_POS] |=>
			!state_reg.flags[timer16_pkg::CMP_A_POS]
			&& state_reg.counter_value == $past(state_reg.counter_value)
				+ ($past(tick) ? count_one : '0);
	endproperty
	a_force_no_flag: assert property (p_force_no_flag) else $error("force set flag");

	sequence s_counter_write;
		wr_cnt ##1 !wr_cnt [*1];
	endsequence

	property p_block;
		@(posedge pclk) disable iff (!presetn)
		s_counter_write ##0 (tick && match_a) |-> !ev_a;
	endproperty
	a_block: assert property (p_block) else $error("match after counter write");

	property p_wrap;
		@(posedge pclk) disable iff (!presetn)
		state_reg.wgm == timer16_pkg::WGM_NORMAL && tick && !wr_cnt
			&& state_reg.counter_value == count_max
			|=> state_reg.counter_value == '0 && state_reg.flags[timer16_pkg::OVF_POS];
	endproperty
	a_wrap: assert property (p_wrap) else $error("normal wrap or overflow wrong");

	property p_count_up;
		@(posedge pclk) disable iff (!presetn)
		state_reg.wgm == timer16_pkg::WGM_NORMAL && tick && !wr_cnt
			|=> state_reg.counter_value == $past(state_reg.counter_value) + count_one;
	endproperty
	a_count_up: assert property (p_count_up) else $error("normal mode did not increment");

	property p_ovf_ack;
		@(posedge pclk) disable iff (!presetn)
		overflow_ack && !ovf_set |=> !state_reg.flags[timer16_pkg::OVF_POS];
	endproperty
	a_ovf_ack: assert property (p_ovf_ack) else $error("overflow not cleared");

	property p_flag_set;
		@(posedge pclk) disable iff (!presetn)
		ev_b |=> state_reg.flags[timer16_pkg::CMP_B_POS] ##1 state_reg.irq == state_reg.irq_en[2]
			|| state_reg.flags[1:0] != 2'h0 || !state_reg.flags[2];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("match flag not set");

	property p_w1c;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == timer16_pkg::OFF_FLAGS && pwdata[timer16_pkg::CMP_A_POS] && !ev_a
			|=> !state_reg.flags[timer16_pkg::CMP_A_POS];
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

	property p_pin_source;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> pin_out[0] == (($past(state_reg.com_a) != timer16_pkg::COM_NONE)
			? $past(oc_a) : $past(state_reg.port_val[0]))
			&& pin_oe == $past(state_reg.pin_direction_bit);
	endproperty
	a_pin_source: assert property (p_pin_source) else $error("pin source wrong");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		irq == |(state_reg.flags & state_reg.irq_en);
	endproperty
	a_irq: assert property (p_irq) else $error("irq disagrees with flags");

	property p_pin_source_b;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> pin_out[1] == (($past(state_reg.com_b) != timer16_pkg::COM_NONE)
			? $past(oc_b) : $past(state_reg.port_val[1]));
	endproperty
	a_pin_source_b: assert property (p_pin_source_b) else $error("pin b source wrong");

	property p_flag_set_a;
		@(posedge pclk) disable iff (!presetn)
		ev_a |=> state_reg.flags[timer16_pkg::CMP_A_POS];
	endproperty
	a_flag_set_a: assert property (p_flag_set_a) else $error("match a flag not set");

	property p_top_clear;
		@(posedge pclk) disable iff (!presetn)
		top_clear |=> state_reg.counter_value == '0;
	endproperty
	a_top_clear: assert property (p_top_clear) else $error("top match did not clear");

	// A blocked TOP match must let the counter step on
	property p_top_skip;
		@(posedge pclk) disable iff (!presetn)
		tick && !wr_cnt && state_reg.block && state_reg.wgm == timer16_pkg::WGM_FAST_PWM_A
			|=> state_reg.counter_value == $past(state_reg.counter_value) + count_one;
	endproperty
	a_top_skip: assert property (p_top_skip) else $error("blocked top cleared counter");

endmodule // timer16_compare_output_normal

// File: timer16_compare_output_normal_test.sv
module timer16_compare_output_normal_test;
	timeunit 1ns;
	timeprecision 1ps;

	// Design inputs
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic timer_tick = 1'b0;
	logic overflow_ack = 1'b0;
	logic [1:0] compare_ack = 2'h0;
	// Design outputs and pad
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [1:0] pin_out;
	logic [1:0] pin_oe;
	logic [1:0] pad_level;
	// Bench state
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [31:0] rdv;
	logic errv;
	logic [1:0] oc;
	logic [15:0] rnd = 16'h002D;
	logic [15:0] r;
	logic [1:0] seq [7] = '{timer16_pkg::COM_SET, timer16_pkg::COM_NONE, timer16_pkg::COM_CLEAR,
		timer16_pkg::COM_NONE, timer16_pkg::COM_TOGGLE, timer16_pkg::COM_TOGGLE, timer16_pkg::COM_SET};

	always #2 pclk = ~pclk;

	timer16_compare_output_normal i_timer16_compare_output_normal (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
		.overflow_ack(overflow_ack), .compare_ack(compare_ack), .irq(irq),
		.pin_out(pin_out), .pin_oe(pin_oe));

	pin_pad_model i_pin_pad_model (.pin_out(pin_out), .pin_oe(pin_oe), .pad_level(pad_level));

	// Next pseudo-random value
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Output register after a match or force
	function automatic logic act(input logic [1:0] m, input logic o);
		case (m)
			timer16_pkg::COM_TOGGLE: return ~o;
			timer16_pkg::COM_CLEAR: return 1'b0;
			timer16_pkg::COM_SET: return 1'b1;
			default: return o;
		endcase
	endfunction

	task final_report;
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task check_reg(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task check_pin(input logic [1:0] got, input logic [1:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t pin got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task rc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		check_reg(rdv, e);
	endtask

	task ctl(input logic [3:0] w, input logic [1:0] b, input logic [1:0] a);
		wr(timer16_pkg::OFF_CONTROL_A, {24'h0, w, b, a});
	endtask

	// One timer clock cycle
	task tick;
		@(posedge pclk);
		timer_tick <= 1'b1;
		@(posedge pclk);
		timer_tick <= 1'b0;
	endtask

	// Hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			final_report;
		end
	end

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rc(timer16_pkg::OFF_STATUS, 32'h0);
		rc(timer16_pkg::OFF_FLAGS, 32'h0);
		xfer(1'b0, 8'h28, 32'h0);
		check_pin({1'b0, errv}, 2'h1);
		// Force every output action on channel A
		oc = 2'h0;
		for (int i = 0; i < 7; i++) begin
			ctl(timer16_pkg::WGM_NORMAL, timer16_pkg::COM_NONE, seq[i]);
			wr(timer16_pkg::OFF_CONTROL_C, 32'h1);
			oc[0] = act(seq[i], oc[0]);
			rc(timer16_pkg::OFF_STATUS, {30'h0, oc});
		end
		ctl(timer16_pkg::WGM_NORMAL, timer16_pkg::COM_SET, timer16_pkg::COM_NONE);
		wr(timer16_pkg::OFF_CONTROL_C, 32'h2);
		oc[1] = act(timer16_pkg::COM_SET, oc[1]);
		rc(timer16_pkg::OFF_STATUS, {30'h0, oc});
		rc(timer16_pkg::OFF_FLAGS, 32'h0);
		rc(timer16_pkg::OFF_COUNTER, 32'h0);
		// Pin override and direction
		wr(timer16_pkg::OFF_PORT, 32'h0);
		repeat (2) @(posedge pclk);
		check_pin(pad_level, 2'h0);
		ctl(timer16_pkg::WGM_NORMAL, timer16_pkg::COM_NONE, timer16_pkg::COM_SET);
		wr(timer16_pkg::OFF_PORT, 32'h30);
		repeat (2) @(posedge pclk);
		check_pin(pad_level, 2'h1);
		// Mode changes keep the output register; force ignored in PWM
		ctl(timer16_pkg::WGM_CTC_A, timer16_pkg::COM_NONE, timer16_pkg::COM_SET);
		ctl(timer16_pkg::WGM_FAST_PWM_A, timer16_pkg::COM_NONE, timer16_pkg::COM_CLEAR);
		wr(timer16_pkg::OFF_CONTROL_C, 32'h3);
		ctl(timer16_pkg::WGM_NORMAL, timer16_pkg::COM_NONE, timer16_pkg::COM_NONE);
		rc(timer16_pkg::OFF_STATUS, 32'h3);
		// Wrap at maximum with overflow flag and interrupt
		wr(timer16_pkg::OFF_IRQ_ENABLE, 32'h1);
		wr(timer16_pkg::OFF_COUNTER, 32'hFFFE);
		wr(timer16_pkg::OFF_CONTROL_B, 32'h1);
		tick;
		rc(timer16_pkg::OFF_COUNTER, 32'hFFFF);
		check_pin({1'b0, irq}, 2'h0);
		tick;
		rc(timer16_pkg::OFF_COUNTER, 32'h0);
		rc(timer16_pkg::OFF_FLAGS, 32'h1);
		check_pin({1'b0, irq}, 2'h1);
		@(posedge pclk);
		overflow_ack <= 1'b1;
		@(posedge pclk);
		overflow_ack <= 1'b0;
		rc(timer16_pkg::OFF_FLAGS, 32'h0);
		// Random compare matches, blocked and unblocked
		ctl(timer16_pkg::WGM_NORMAL, timer16_pkg::COM_NONE, timer16_pkg::COM_TOGGLE);
		wr(timer16_pkg::OFF_IRQ_ENABLE, 32'h7);
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			r = {1'b0, rnd[14:1], 1'b1};
			wr(timer16_pkg::OFF_COMPARE_A, {16'h0, r});
			wr(timer16_pkg::OFF_CONTROL_B, 32'h0);
			wr(timer16_pkg::OFF_COUNTER, {16'h0, r});
			wr(timer16_pkg::OFF_CONTROL_B, 32'h1);
			tick;
			rc(timer16_pkg::OFF_FLAGS, 32'h0);
			wr(timer16_pkg::OFF_COUNTER, {16'h0, r - 16'h1});
			tick;
			tick;
			oc[0] = ~oc[0];
			rc(timer16_pkg::OFF_FLAGS, 32'h2);
			rc(timer16_pkg::OFF_COUNTER, {16'h0, r + 16'h1});
			rc(timer16_pkg::OFF_STATUS, {30'h0, oc});
			check_pin({1'b0, irq}, 2'h1);
			check_pin(pad_level, {1'b0, oc[0]});
			if (k[0]) begin
				@(posedge pclk);
				compare_ack <= 2'h1;
				@(posedge pclk);
				compare_ack <= 2'h0;
			end else begin
				wr(timer16_pkg::OFF_FLAGS, 32'h2);
			end
			rc(timer16_pkg::OFF_FLAGS, 32'h0);
		end
		// Blocked TOP in PWM counts on; the next TOP clears and sets flags
		ctl(timer16_pkg::WGM_FAST_PWM_A, timer16_pkg::COM_NONE, timer16_pkg::COM_NONE);
		wr(timer16_pkg::OFF_COMPARE_A, 32'h40);
		wr(timer16_pkg::OFF_COMPARE_B, 32'h40);
		wr(timer16_pkg::OFF_COUNTER, 32'h40);
		tick;
		rc(timer16_pkg::OFF_COUNTER, 32'h41);
		rc(timer16_pkg::OFF_FLAGS, 32'h0);
		wr(timer16_pkg::OFF_COUNTER, 32'h3F);
		tick;
		tick;
		rc(timer16_pkg::OFF_COUNTER, 32'h0);
		rc(timer16_pkg::OFF_FLAGS, 32'h7);
		check_pin({1'b0, irq}, 2'h1);
		wr(timer16_pkg::OFF_FLAGS, 32'h7);
		rc(timer16_pkg::OFF_FLAGS, 32'h0);
		rc(timer16_pkg::OFF_STATUS, {30'h0, oc});
		final_report;
	end
endmodule // timer16_compare_output_normal_test

// File: timer16_pkg.sv
package timer16_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CONTROL_A = 8'h00;
	localparam logic [7:0] OFF_CONTROL_B = 8'h04;
	localparam logic [7:0] OFF_CONTROL_C = 8'h08;
	localparam logic [7:0] OFF_COUNTER = 8'h0C;
	localparam logic [7:0] OFF_COMPARE_A = 8'h10;
	localparam logic [7:0] OFF_COMPARE_B = 8'h14;
	localparam logic [7:0] OFF_FLAGS = 8'h18;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1C;
	localparam logic [7:0] OFF_PORT = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;

	// Field positions in timer_control_a
	localparam int COM_A_POS = 0;
	localparam int COM_B_POS = 2;
	localparam int WGM_POS = 4;
	// Field positions in timer_control_b and timer_control_c
	localparam int RUN_POS = 0;
	localparam int FORCE_A_POS = 0;
	localparam int FORCE_B_POS = 1;
	// Bits of timer_flag_register and the enable register
	localparam int OVF_POS = 0;
	localparam int CMP_A_POS = 1;
	localparam int CMP_B_POS = 2;
	// Fields of the port register
	localparam int PORT_VAL_POS = 0;
	localparam int PORT_DIR_POS = 4;

	// Waveform mode codes
	localparam logic [3:0] WGM_NORMAL = 4'h0;
	localparam logic [3:0] WGM_CTC_A = 4'h4;
	localparam logic [3:0] WGM_FAST_PWM_A = 4'hF;

	// Compare output mode codes
	localparam logic [1:0] COM_NONE = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;

	// Reset values
	localparam logic [1:0] COM_RESET = 2'h0;
	localparam logic [3:0] WGM_RESET = 4'h0;
	localparam logic [2:0] FLAGS_RESET = 3'h0;
	localparam logic OC_RESET = 1'b0;

endpackage
